// File: shared/svfo_regs.svh
// constants for the supervisor fault-output and self-test block
`ifndef SVFO_REGS_SVH
`define SVFO_REGS_SVH
`define SVFO_NCH 8
`define SVFO_MCLK_PERIOD_NS 40
`define SVFO_SETTLE_NS 2000
`define SVFO_RESET_DELAY_SEL_MIN_NS 200000
`define SVFO_SEQUENCE_TIMEOUT_NS 1000000
`define SVFO_SELF_TEST_NS 100000
`define SVFO_SETTLE_CYC ((`SVFO_SETTLE_NS + `SVFO_MCLK_PERIOD_NS - 1) / `SVFO_MCLK_PERIOD_NS)
`define SVFO_SELF_TEST_CYC ((`SVFO_SELF_TEST_NS + `SVFO_MCLK_PERIOD_NS - 1) / `SVFO_MCLK_PERIOD_NS)
`define SVFO_CFG_TEST 2'h0
`define SVFO_CFG_VCTL 2'h1
`define SVFO_CFG_IEN 2'h2
`define SVFO_OTP_TEST 8'h01
`define SVFO_OTP_VCTL 8'h00
`define SVFO_OTP_IEN 8'h01
`define SVFO_TEST_SELFTEST_AT_POWERUP 0
`define SVFO_TEST_SELFTEST_AT_SHUTDOWN 1
`define SVFO_CW_SELFTEST_AT_POWERUP 3
`define SVFO_IEN_DONE 0
`define SVFO_RES_PASS 0
`define SVFO_RES_FAIL 1
`define SVFO_RES_SEC 2
`define SVFO_RES_DED 3
`define SVFO_DG_MAX 4'hB
`define SVFO_DLY_M0 1
`define SVFO_DLY_M1 5
`define SVFO_DLY_M2 10
`define SVFO_DLY_M3 50
`define SVFO_DLY_M4 100
`define SVFO_DLY_M5 250
`define SVFO_DLY_M6 500
`define SVFO_DLY_M7 1000
`define SVFO_SELF_TEST_PAT 8'hA5
`define SVFO_SELF_TEST_FLIP_A 13'h0020
`define SVFO_SELF_TEST_FLIP_B 13'h0104
`endif

// File: shared/svfo_pkg.sv
// types and error-code functions for the supervisor block
package svfo_pkg;
  typedef enum logic [3:0] {
    ST_POR = 4'h0, ST_DECIDE = 4'h1, ST_SELF_TEST = 4'h2, ST_LOAD = 4'h3, ST_IDLE = 4'h4,
    ST_SEQ_ON = 4'h5, ST_ACTIVE = 4'h6, ST_SEQ_OFF = 4'h7, ST_SAFE_HALT_STATE = 4'h8
  } svfo_state_e;
  typedef logic [12:0] svfo_cw_t;
  typedef struct packed {logic [7:0] data; logic sec; logic ded;} svfo_dec_s;

  // hamming positions 1..12, bit 0 holds overall parity
  function automatic svfo_cw_t svfo_enc(input logic [7:0] d);
    svfo_cw_t c;
    int j;
    c = '0;
    j = 0;
    for (int i = 1; i < 13; i++) if ((i & (i - 1)) != 0) begin
      c[i] = d[j];
      j++;
    end
    for (int k = 0; k < 4; k++) for (int i = 1; i < 13; i++) if (((i >> k) & 1) == 1 && i != (1 << k)) begin
      c[1 << k] = c[1 << k] ^ c[i];
    end
    c[0] = ^c[12:1];
    return c;
  endfunction : svfo_enc

  function automatic svfo_dec_s svfo_dec(input svfo_cw_t cin);
    svfo_cw_t c;
    logic [3:0] s;
    logic p;
    svfo_dec_s r;
    int j;
    c = cin;
    s = '0;
    j = 0;
    for (int i = 1; i < 13; i++) if (c[i]) s = s ^ 4'(i);
    p = ^c;
    if (p && s != 4'h0 && s < 4'hD) c[s] = ~c[s];
    r.sec = p;
    r.ded = !p && s != 4'h0;
    r.data = '0;
    for (int i = 1; i < 13; i++) if ((i & (i - 1)) != 0) begin
      r.data[j] = c[i];
      j++;
    end
    return r;
  endfunction : svfo_dec
endpackage : svfo_pkg

// File: shared/svfo_otp_if.sv
// read port between the sequencer and the one-time configuration memory
`timescale 1ns/1ps
interface svfo_otp_if;
  logic [1:0] addr;
  svfo_pkg::svfo_cw_t rdata;
  modport ctrl (output addr, input rdata);
  modport mem (input addr, output rdata);
endinterface : svfo_otp_if

// File: logic/svfo_otp_mem.sv
// one-time configuration memory, error-coded words with registered read data
`timescale 1ns/1ps
`include "svfo_regs.svh"
module svfo_otp_mem (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // read port
  svfo_otp_if.mem otp
);
  function automatic logic [7:0] svfo_rom(input logic [1:0] a);
    if (a == `SVFO_CFG_TEST) begin
      return `SVFO_OTP_TEST;
    end else if (a == `SVFO_CFG_VCTL) begin
      return `SVFO_OTP_VCTL;
    end else if (a == `SVFO_CFG_IEN) begin
      return `SVFO_OTP_IEN;
    end else begin
      return 8'h00;
    end
  endfunction : svfo_rom

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      otp.rdata <= '0;
    end else if (ce) begin
      otp.rdata <= svfo_pkg::svfo_enc(svfo_rom(otp.addr));
    end
  end
endmodule : svfo_otp_mem

// File: logic/svfo_top.sv
// supervisor fault outputs, reset output and self-test sequencing
// How it works
// - per-channel deglitch on fast OV and UV
// - in-window voltage leaves outputs released
// - fast OV or UV latches interrupt low
// - clear needs fault gone plus write one
// - unmapping never releases an asserted interrupt
// - reset release delay programmable 0.2 to 200ms
// - reset held low until self-test finishes
// - sensed reset pin differing raises mismatch
// - mismatch check waits settling after toggle
// - mapped channels' fast faults drive reset
// - back in window, delay then release
// - delay chosen by three-bit control field
// - self-test at power-up or shutdown if enabled
// - self-test releases irq, i2c, holds reset
// - after pass: i2c on, load, idle
// - configuration load single-correct double-detect coded
// - failure or double error enters safe halt
// - four-bit result field readable by host
// - test done sets flag, irq, status
// - activate rise masks selected undervoltage until off/timeout
// - sleep ignored until active and timed out
// - power-up test decision uses raw bit
// - idle state disables OV and UV monitoring
`timescale 1ns/1ps
`include "svfo_regs.svh"
module svfo_top #(
  parameter int unsigned RESET_DELAY_SEL_MIN_CYC = (`SVFO_RESET_DELAY_SEL_MIN_NS + `SVFO_MCLK_PERIOD_NS - 1) / `SVFO_MCLK_PERIOD_NS,
  parameter int unsigned SEQUENCE_TIMEOUT_CYC = `SVFO_SEQUENCE_TIMEOUT_NS / `SVFO_MCLK_PERIOD_NS
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // asynchronous comparator and pin inputs
  input wire logic [`SVFO_NCH-1:0] overvoltage_fast,
  input wire logic [`SVFO_NCH-1:0] undervoltage_fast,
  input wire logic [`SVFO_NCH-1:0] monitor_above_off,
  input wire logic activate_pin,
  input wire logic sleep_pin_n,
  input wire logic reset_out_n_i,
  // host configuration
  input wire logic [4*`SVFO_NCH-1:0] deglitch_setting,
  input wire logic [`SVFO_NCH-1:0] ov_irq_en,
  input wire logic [`SVFO_NCH-1:0] uv_irq_en,
  input wire logic [`SVFO_NCH-1:0] reset_fault_map,
  input wire logic [`SVFO_NCH-1:0] powerup_automask_select,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  // host write-one clears
  input wire logic [`SVFO_NCH-1:0] ov_clr,
  input wire logic [`SVFO_NCH-1:0] uv_clr,
  input wire logic mismatch_clr,
  input wire logic selftest_done_clr,
  input wire logic selftest_fail_clr,
  // open-drain pins
  output logic fault_irq_n_o,
  output logic fault_irq_oe_n,
  output logic reset_out_n_o,
  output logic reset_out_oe_n,
  // status
  output logic i2c_enable,
  output logic sleep_mode,
  output logic [`SVFO_NCH-1:0] ov_flag,
  output logic [`SVFO_NCH-1:0] uv_flag,
  output logic reset_pin_mismatch,
  output logic selftest_done_flag,
  output logic selftest_done_status,
  output logic selftest_fail_flag,
  output logic [3:0] selftest_result,
  output logic [7:0] test_cfg,
  output logic [7:0] vendor_control_reg,
  output logic [7:0] test_event_enables,
  output svfo_pkg::svfo_state_e state
);
  localparam int unsigned NCH = `SVFO_NCH;
  localparam int unsigned SW = 3 * NCH + 3;
  localparam logic [23:0] SEQ_LAST = 24'(SEQUENCE_TIMEOUT_CYC - 1);
  localparam logic [23:0] SELF_TEST_LAST = 24'(`SVFO_SELF_TEST_CYC - 1);
  localparam logic [7:0] SETTLE = 8'(`SVFO_SETTLE_CYC);

  function automatic logic [11:0] svfo_dg_limit(input logic [3:0] s);
    logic [3:0] e;
    e = (s > `SVFO_DG_MAX) ? `SVFO_DG_MAX : s;
    return 12'h001 << e;
  endfunction : svfo_dg_limit

  function automatic logic [23:0] svfo_dly_cyc(input logic [2:0] sel);
    int unsigned m;
    case (sel)
      3'h0: m = `SVFO_DLY_M0;
      3'h1: m = `SVFO_DLY_M1;
      3'h2: m = `SVFO_DLY_M2;
      3'h3: m = `SVFO_DLY_M3;
      3'h4: m = `SVFO_DLY_M4;
      3'h5: m = `SVFO_DLY_M5;
      3'h6: m = `SVFO_DLY_M6;
      default: m = `SVFO_DLY_M7;
    endcase
    return 24'(RESET_DELAY_SEL_MIN_CYC * m);
  endfunction : svfo_dly_cyc

  function automatic logic svfo_self_test_ok();
    svfo_pkg::svfo_cw_t c;
    svfo_pkg::svfo_dec_s a;
    svfo_pkg::svfo_dec_s b;
    c = svfo_pkg::svfo_enc(`SVFO_SELF_TEST_PAT);
    a = svfo_pkg::svfo_dec(c ^ `SVFO_SELF_TEST_FLIP_A);
    b = svfo_pkg::svfo_dec(c ^ `SVFO_SELF_TEST_FLIP_B);
    return a.sec && !a.ded && a.data == `SVFO_SELF_TEST_PAT && b.ded;
  endfunction : svfo_self_test_ok

  svfo_otp_if otp ();
  svfo_otp_mem u_otp (.mclk(mclk), .resetn(resetn), .ce(ce), .otp(otp));

  // two-flop synchronisers for everything from outside the clock domain
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (ce) begin
      sync1_q <= {monitor_above_off, undervoltage_fast, overvoltage_fast, activate_pin, sleep_pin_n, reset_out_n_i};
      sync2_q <= sync1_q;
    end
  end
  logic pin_s;
  logic sleep_s;
  logic act_s;
  logic [2*NCH-1:0] comp_s;
  logic [NCH-1:0] above_s;
  assign pin_s = sync2_q[0];
  assign sleep_s = sync2_q[1];
  assign act_s = sync2_q[2];
  assign comp_s = sync2_q[2*NCH+2:3];
  assign above_s = sync2_q[SW-1:2*NCH+3];

  // deglitch filters, ov channels low half, uv channels high half
  logic [2*NCH-1:0] comp_f;
  for (genvar g = 0; g < 2 * NCH; g++) begin : g_dg
    logic [11:0] cnt_q;
    logic f_q;
    logic [11:0] lim;
    assign lim = svfo_dg_limit(deglitch_setting[(g % NCH) * 4 +: 4]);
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        cnt_q <= '0;
        f_q <= 1'b0;
      end else if (ce) begin
        if (comp_s[g] == f_q) begin
          cnt_q <= '0;
        end else if (cnt_q + 12'h001 >= lim) begin
          f_q <= comp_s[g];
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + 12'h001;
        end
      end
    end
    assign comp_f[g] = f_q;
  end

  svfo_pkg::svfo_state_e state_d;
  logic [23:0] tmr_q;
  logic [1:0] ld_idx_q;
  logic ld_wait_q;
  logic ld_ded_q;
  logic [NCH-1:0] amask_q;
  logic mon_en;
  logic hold_rst;
  logic self_test_end;
  logic self_test_pass;
  logic [NCH-1:0] ov_hit;
  logic [NCH-1:0] uv_hit;
  svfo_pkg::svfo_dec_s ld_dec;
  logic ld_take;

  assign mon_en = state == svfo_pkg::ST_SEQ_ON || state == svfo_pkg::ST_ACTIVE
                  || state == svfo_pkg::ST_SEQ_OFF;
  assign hold_rst = state == svfo_pkg::ST_POR || state == svfo_pkg::ST_DECIDE || state == svfo_pkg::ST_SELF_TEST
                    || state == svfo_pkg::ST_LOAD || state == svfo_pkg::ST_SAFE_HALT_STATE
                    || state_d == svfo_pkg::ST_SELF_TEST;
  assign ov_hit = comp_f[NCH-1:0] & {NCH{mon_en}};
  assign uv_hit = comp_f[2*NCH-1:NCH] & ~amask_q & {NCH{mon_en}};
  assign self_test_end = state == svfo_pkg::ST_SELF_TEST && tmr_q == SELF_TEST_LAST;
  assign self_test_pass = svfo_self_test_ok();
  assign otp.addr = ld_idx_q;
  assign ld_dec = svfo_pkg::svfo_dec(otp.rdata);
  assign ld_take = state == svfo_pkg::ST_LOAD && ld_wait_q;

  // sequencer
  always_comb begin
    state_d = state;
    case (state)
      svfo_pkg::ST_POR: state_d = svfo_pkg::ST_DECIDE;
      svfo_pkg::ST_DECIDE: begin
        if (otp.rdata[`SVFO_CW_SELFTEST_AT_POWERUP]) begin
          state_d = svfo_pkg::ST_SELF_TEST;
        end else begin
          state_d = svfo_pkg::ST_LOAD;
        end
      end
      svfo_pkg::ST_SELF_TEST: begin
        if (self_test_end) begin
          state_d = self_test_pass ? svfo_pkg::ST_LOAD : svfo_pkg::ST_SAFE_HALT_STATE;
        end
      end
      svfo_pkg::ST_LOAD: begin
        if (ld_take && ld_dec.ded) begin
          state_d = svfo_pkg::ST_SAFE_HALT_STATE;
        end else if (ld_take && ld_idx_q == `SVFO_CFG_IEN) begin
          state_d = svfo_pkg::ST_IDLE;
        end
      end
      svfo_pkg::ST_IDLE: begin
        if (act_s) begin
          state_d = svfo_pkg::ST_SEQ_ON;
        end
      end
      svfo_pkg::ST_SEQ_ON: begin
        if (!act_s) begin
          state_d = svfo_pkg::ST_SEQ_OFF;
        end else if (tmr_q == SEQ_LAST) begin
          state_d = svfo_pkg::ST_ACTIVE;
        end
      end
      svfo_pkg::ST_ACTIVE: begin
        if (!act_s) begin
          state_d = svfo_pkg::ST_SEQ_OFF;
        end
      end
      svfo_pkg::ST_SEQ_OFF: begin
        if (tmr_q == SEQ_LAST) begin
          state_d = test_cfg[`SVFO_TEST_SELFTEST_AT_SHUTDOWN] ? svfo_pkg::ST_SELF_TEST : svfo_pkg::ST_IDLE;
        end
      end
      default: state_d = svfo_pkg::ST_SAFE_HALT_STATE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= svfo_pkg::ST_POR;
      tmr_q <= '0;
    end else if (ce) begin
      state <= state_d;
      tmr_q <= (state_d != state) ? 24'h000000 : tmr_q + 24'h000001;
    end
  end

  // configuration load and host writes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ld_idx_q <= `SVFO_CFG_TEST;
      ld_wait_q <= 1'b0;
      test_cfg <= '0;
      vendor_control_reg <= '0;
      test_event_enables <= '0;
    end else if (ce) begin
      if (state == svfo_pkg::ST_LOAD) begin
        ld_wait_q <= ~ld_wait_q;
        if (ld_take) begin
          ld_idx_q <= ld_idx_q + 2'h1;
          if (ld_idx_q == `SVFO_CFG_TEST) begin
            test_cfg <= ld_dec.data;
          end else if (ld_idx_q == `SVFO_CFG_VCTL) begin
            vendor_control_reg <= ld_dec.data;
          end else begin
            test_event_enables <= ld_dec.data;
          end
        end
      end else begin
        ld_idx_q <= `SVFO_CFG_TEST;
        ld_wait_q <= 1'b0;
        if (cfg_wr && i2c_enable) begin
          if (cfg_addr == `SVFO_CFG_TEST) begin
            test_cfg <= cfg_wdata;
          end else if (cfg_addr == `SVFO_CFG_VCTL) begin
            vendor_control_reg <= cfg_wdata;
          end else if (cfg_addr == `SVFO_CFG_IEN) begin
            test_event_enables <= cfg_wdata;
          end
        end
      end
    end
  end

  // power-up automask
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      amask_q <= '0;
    end else if (ce) begin
      if (state == svfo_pkg::ST_IDLE && act_s) begin
        amask_q <= powerup_automask_select;
      end else if (state != svfo_pkg::ST_SEQ_ON || tmr_q == SEQ_LAST) begin
        amask_q <= '0;
      end else begin
        amask_q <= amask_q & ~above_s;
      end
    end
  end

  // latched voltage fault flags, set wins over clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ov_flag <= '0;
      uv_flag <= '0;
    end else if (ce) begin
      ov_flag <= (ov_flag & ~(ov_clr & ~ov_hit)) | ov_hit;
      uv_flag <= (uv_flag & ~(uv_clr & ~uv_hit)) | uv_hit;
    end
  end

  // self-test outcome
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      selftest_done_flag <= 1'b0;
      selftest_done_status <= 1'b0;
      selftest_fail_flag <= 1'b0;
      selftest_result <= '0;
      ld_ded_q <= 1'b0;
    end else if (ce) begin
      selftest_done_flag <= self_test_end | (selftest_done_flag & ~selftest_done_clr);
      selftest_fail_flag <= (self_test_end & ~self_test_pass) | (ld_take & ld_dec.ded)
                            | (selftest_fail_flag & ~selftest_fail_clr);
      ld_ded_q <= ld_take & ld_dec.ded;
      if (state != svfo_pkg::ST_SELF_TEST && state_d == svfo_pkg::ST_SELF_TEST) begin
        selftest_done_status <= 1'b0;
        selftest_result <= '0;
      end else begin
        if (self_test_end) begin
          selftest_done_status <= 1'b1;
          selftest_result[`SVFO_RES_PASS] <= self_test_pass;
          selftest_result[`SVFO_RES_FAIL] <= ~self_test_pass;
        end
        if (ld_take && ld_dec.sec) begin
          selftest_result[`SVFO_RES_SEC] <= 1'b1;
        end
        if (ld_take && ld_dec.ded) begin
          selftest_result[`SVFO_RES_DED] <= 1'b1;
        end
      end
    end
  end

  // reset output: hold, mapped faults, release delay
  logic [23:0] rst_cnt_q;
  logic rst_fault;
  assign rst_fault = |((ov_hit | uv_hit) & reset_fault_map);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reset_out_oe_n <= 1'b0;
      reset_out_n_o <= 1'b0;
      rst_cnt_q <= '0;
    end else if (ce) begin
      reset_out_n_o <= 1'b0;
      if (hold_rst || rst_fault) begin
        reset_out_oe_n <= 1'b0;
        rst_cnt_q <= '0;
      end else if (!reset_out_oe_n) begin
        if (rst_cnt_q + 24'h000001 >= svfo_dly_cyc(vendor_control_reg[2:0])) begin
          reset_out_oe_n <= 1'b1;
          rst_cnt_q <= '0;
        end else begin
          rst_cnt_q <= rst_cnt_q + 24'h000001;
        end
      end
    end
  end

  // reset pin mismatch after settling
  logic oe_prev_q;
  logic [7:0] settle_q;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      oe_prev_q <= 1'b0;
      settle_q <= '0;
      reset_pin_mismatch <= 1'b0;
    end else if (ce) begin
      oe_prev_q <= reset_out_oe_n;
      if (oe_prev_q != reset_out_oe_n) begin
        settle_q <= '0;
      end else if (settle_q != SETTLE) begin
        settle_q <= settle_q + 8'h01;
      end
      reset_pin_mismatch <= (settle_q == SETTLE && oe_prev_q == reset_out_oe_n && pin_s != reset_out_oe_n)
                            | (reset_pin_mismatch & ~mismatch_clr);
    end
  end

  // interrupt output, latched until every flag is clear or self-test starts
  logic irq_set;
  logic any_flag;
  assign irq_set = |(ov_flag & ov_irq_en) | |(uv_flag & uv_irq_en) | reset_pin_mismatch | selftest_fail_flag
                   | (selftest_done_flag & test_event_enables[`SVFO_IEN_DONE]);
  assign any_flag = |ov_flag | |uv_flag | reset_pin_mismatch | selftest_fail_flag | selftest_done_flag;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fault_irq_oe_n <= 1'b1;
      fault_irq_n_o <= 1'b0;
    end else if (ce) begin
      fault_irq_n_o <= 1'b0;
      if (state == svfo_pkg::ST_SELF_TEST) begin
        fault_irq_oe_n <= 1'b1;
      end else if (irq_set || state == svfo_pkg::ST_SAFE_HALT_STATE) begin
        fault_irq_oe_n <= 1'b0;
      end else if (!any_flag) begin
        fault_irq_oe_n <= 1'b1;
      end
    end
  end

  // i2c enable and sleep tracking
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      i2c_enable <= 1'b0;
      sleep_mode <= 1'b0;
    end else if (ce) begin
      i2c_enable <= state_d != svfo_pkg::ST_POR && state_d != svfo_pkg::ST_DECIDE
                    && state_d != svfo_pkg::ST_SELF_TEST;
      sleep_mode <= state == svfo_pkg::ST_ACTIVE && !sleep_s;
    end
  end
endmodule : svfo_top

// File: sim/svfo_checker.sv
// concurrent checks on the supervisor top ports
`timescale 1ns/1ps
module svfo_checker #(
  parameter int unsigned RESET_DELAY_SEL_MIN_CYC = 4,
  parameter int unsigned SEQUENCE_TIMEOUT_CYC = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // pins and inputs
  input wire logic reset_out_n_i,
  input wire logic [7:0] ov_irq_en,
  input wire logic [7:0] reset_fault_map,
  input wire logic [7:0] ov_clr,
  input wire logic fault_irq_oe_n,
  input wire logic reset_out_oe_n,
  // flags and state
  input wire logic [7:0] ov_flag,
  input wire logic [7:0] uv_flag,
  input wire logic reset_pin_mismatch,
  input wire logic selftest_fail_flag,
  input wire logic selftest_done_flag,
  input wire svfo_pkg::svfo_state_e state
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic any_flag;
  logic oe_prev_q;
  logic [7:0] calm_q;
  logic [15:0] seq_cnt_q;
  assign any_flag = |{ov_flag, uv_flag, reset_pin_mismatch, selftest_fail_flag, selftest_done_flag};
  // cycles spent in the power-up sequence
  always_ff @(posedge mclk) begin
    if (!resetn || state != svfo_pkg::ST_SEQ_ON) seq_cnt_q <= 16'h0000;
    else seq_cnt_q <= seq_cnt_q + 16'h0001;
  end
  // cycles since the reset drive last changed, saturating
  always_ff @(posedge mclk) begin
    oe_prev_q <= reset_out_oe_n;
    if (!resetn || reset_out_oe_n != oe_prev_q) calm_q <= 8'h00;
    else if (calm_q != 8'hFF) calm_q <= calm_q + 8'h01;
  end
  rst_in_self_test_a: assert property (state == svfo_pkg::ST_SELF_TEST |-> !reset_out_oe_n)
    else $error("reset released during self-test");
  irq_in_self_test_a: assert property ((state == svfo_pkg::ST_SELF_TEST) [*2] |-> fault_irq_oe_n || selftest_fail_flag)
    else $error("interrupt driven during self-test");
  irq_hold_a: assert property (!fault_irq_oe_n && any_flag && state != svfo_pkg::ST_SEQ_OFF
    |=> !fault_irq_oe_n || state == svfo_pkg::ST_SELF_TEST) else $error("interrupt released with a flag set");
  irq_assert_a: assert property (state == svfo_pkg::ST_ACTIVE && |(ov_flag & ov_irq_en) |=> !fault_irq_oe_n)
    else $error("enabled flag without interrupt");
  irq_release_a: assert property (state == svfo_pkg::ST_ACTIVE && !any_flag |=> fault_irq_oe_n)
    else $error("interrupt held with no flag");
  rst_map_a: assert property (state == svfo_pkg::ST_ACTIVE && |(ov_flag & ~$past(ov_flag) & reset_fault_map)
    |-> !reset_out_oe_n) else $error("mapped fault without reset");
  flag_sticky_a: assert property ($past(resetn) |-> &(ov_flag | ~($past(ov_flag) & ~$past(ov_clr))))
    else $error("flag fell without a clear");
  mismatch_cause_a: assert property ($rose(reset_pin_mismatch) |-> $past(reset_out_n_i, 2) != reset_out_oe_n
    || $past(reset_out_n_i, 3) != reset_out_oe_n || $past(reset_out_n_i, 4) != reset_out_oe_n)
    else $error("mismatch with matching pin");
  settle_quiet_a: assert property ($rose(reset_pin_mismatch) |-> calm_q >= 8'h30)
    else $error("mismatch inside settling time");
  seq_time_a: assert property (state == svfo_pkg::ST_ACTIVE && $past(state) == svfo_pkg::ST_SEQ_ON
    |-> seq_cnt_q + 1 >= SEQUENCE_TIMEOUT_CYC && seq_cnt_q <= SEQUENCE_TIMEOUT_CYC + 1) else $error("sequence timeout length");
  cover property (state == svfo_pkg::ST_ACTIVE && $past(state) == svfo_pkg::ST_SEQ_ON);
  cover property ($rose(|ov_flag));
  cover property ($rose(reset_pin_mismatch));
  cover property (state == svfo_pkg::ST_SELF_TEST && $past(state) == svfo_pkg::ST_SEQ_OFF);
endmodule : svfo_checker

bind svfo_top svfo_checker #(.RESET_DELAY_SEL_MIN_CYC(RESET_DELAY_SEL_MIN_CYC), .SEQUENCE_TIMEOUT_CYC(SEQUENCE_TIMEOUT_CYC)) chk_i (
  .mclk(mclk), .resetn(resetn), .reset_out_n_i(reset_out_n_i), .ov_irq_en(ov_irq_en),
  .reset_fault_map(reset_fault_map), .ov_clr(ov_clr), .fault_irq_oe_n(fault_irq_oe_n),
  .reset_out_oe_n(reset_out_oe_n), .ov_flag(ov_flag), .uv_flag(uv_flag), .reset_pin_mismatch(reset_pin_mismatch),
  .selftest_fail_flag(selftest_fail_flag), .selftest_done_flag(selftest_done_flag), .state(state));

// File: sim/svfo_host_model.sv
// far side of the reset pin: pull-up, sensing input, optional outside pull-down
`timescale 1ns/1ps
module svfo_host_model (
  // drive from the supervisor
  input wire logic reset_out_oe_n,
  input wire logic reset_out_n_o,
  // bench control
  input wire logic ext_low,
  // sensed level
  output logic reset_out_n_i
);
  // a released pin rises through the pull-up unless held low outside
  assign reset_out_n_i = reset_out_oe_n ? !ext_low : reset_out_n_o;
endmodule : svfo_host_model

// File: sim/svfo_bench.sv
// self-checking bench for the supervisor block
`timescale 1ns/1ps
`include "svfo_regs.svh"
module svfo_bench;
  localparam int DMIN = 4;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic act = 1'b0, cfg_wr = 1'b0, mm_clr = 1'b0, dn_clr = 1'b0, ext_low = 1'b0, slp_n = 1'b1;
  logic [1:0] cfg_addr = 2'h0;
  logic [7:0] ovf = 8'h00, uvf = 8'h00, ov_en = 8'h00, rmap = 8'h00, amsk = 8'h00;
  logic [7:0] ov_clr = 8'h00, uv_clr = 8'h00, wdata = 8'h00;
  logic [31:0] dgl = 32'h00000000;
  logic irq_oe_n, rst_oe_n, rst_o, pin, i2c_en, mism, dn_flag, dn_stat, slp;
  logic [7:0] ov_flag, uv_flag, test_cfg, vctl;
  logic [3:0] res;
  svfo_pkg::svfo_state_e state;
  int miscompares = 0;
  int n_tests = 0;
  int dly_mult[8] = '{1, 5, 10, 50, 100, 250, 500, 1000};
  int ch, c2, sel, n, d;
  always #20 mclk = ~mclk;
  svfo_top #(.RESET_DELAY_SEL_MIN_CYC(DMIN), .SEQUENCE_TIMEOUT_CYC(20)) uut (
    .mclk(mclk), .resetn(resetn), .ce(1'b1), .overvoltage_fast(ovf), .undervoltage_fast(uvf),
    .monitor_above_off(8'h00), .activate_pin(act), .sleep_pin_n(slp_n), .reset_out_n_i(pin),
    .deglitch_setting(dgl), .ov_irq_en(ov_en), .uv_irq_en(8'hFF), .reset_fault_map(rmap),
    .powerup_automask_select(amsk), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(wdata),
    .ov_clr(ov_clr), .uv_clr(uv_clr), .mismatch_clr(mm_clr), .selftest_done_clr(dn_clr),
    .selftest_fail_clr(1'b0), .fault_irq_n_o(), .fault_irq_oe_n(irq_oe_n), .reset_out_n_o(rst_o),
    .reset_out_oe_n(rst_oe_n), .i2c_enable(i2c_en), .sleep_mode(slp), .ov_flag(ov_flag), .uv_flag(uv_flag),
    .reset_pin_mismatch(mism), .selftest_done_flag(dn_flag), .selftest_done_status(dn_stat),
    .selftest_fail_flag(), .selftest_result(res), .test_cfg(test_cfg), .vendor_control_reg(vctl),
    .test_event_enables(), .state(state));
  svfo_host_model host (.reset_out_oe_n(rst_oe_n), .reset_out_n_o(rst_o), .ext_low(ext_low), .reset_out_n_i(pin));
  task automatic summarize;
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask : cyc
  function automatic logic [31:0] probe(input int w);
    if (w == 0) return 32'(state);
    if (w == 1) return 32'(rst_oe_n);
    return 32'(mism);
  endfunction : probe
  task automatic wait_for(input int w, input logic [31:0] v, input int lim, output int k);
    k = 0;
    while (probe(w) !== v) begin
      if (k >= lim) begin
        miscompares++;
        summarize();
      end
      cyc(1);
      k++;
    end
  endtask : wait_for
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    cfg_addr = a;
    wdata = v;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(1);
  endtask : wr
  initial begin
    void'($urandom(12680));
    ch = $urandom_range(7);
    c2 = (ch + 1) % 8;
    sel = $urandom_range(7);
    d = DMIN * dly_mult[sel];
    cyc(2);
    chk("state", 32'(svfo_pkg::ST_POR), 32'(state));
    chk("rst_oe_n", 0, rst_oe_n);
    chk("irq_oe_n", 1, irq_oe_n);
    resetn = 1'b1;
    wait_for(0, 32'(svfo_pkg::ST_SELF_TEST), 10, n);
    wait_for(0, 32'(svfo_pkg::ST_LOAD), 3000, n);
    chk("self_test_len", 1, n + 1 >= `SVFO_SELF_TEST_CYC && n <= `SVFO_SELF_TEST_CYC + 1);
    chk("i2c_en", 1, i2c_en);
    wait_for(0, 32'(svfo_pkg::ST_IDLE), 8, n);
    chk("result", 32'h1, 32'(res));
    chk("done", 3, {dn_flag, dn_stat});
    chk("test_cfg", 32'h01, test_cfg);
    wait_for(1, 1, 40, n);
    chk("rst_release", 1, n + 1 >= DMIN && n <= DMIN + 3);
    chk("irq_oe_n", 0, irq_oe_n);
    ovf = 8'hFF;
    cyc(10);
    chk("ov_flag", 0, ov_flag);
    ovf = 8'h00;
    dn_clr = 1'b1;
    cyc(1);
    dn_clr = 1'b0;
    cyc(3);
    chk("irq_oe_n", 1, irq_oe_n);
    wr(2'h1, 8'(sel));
    wr(2'h0, 8'h03);
    chk("cfg", {8'(sel), 8'h03}, {vctl, test_cfg});
    ov_en = 8'hFF;
    rmap = 8'h01 << ch;
    amsk = 8'h01 << c2;
    dgl[4 * c2 +: 4] = 4'h3;
    uvf[c2] = 1'b1;
    act = 1'b1;
    slp_n = 1'b0;
    wait_for(0, 32'(svfo_pkg::ST_SEQ_ON), 6, n);
    cyc(12);
    chk("uv_masked", 0, uv_flag);
    chk("sleep_early", 0, slp);
    wait_for(0, 32'(svfo_pkg::ST_ACTIVE), 30, n);
    cyc(16);
    chk("uv_flag", 32'(8'h01 << c2), uv_flag);
    chk("sleep_mode", 1, slp);
    slp_n = 1'b1;
    uvf = 8'h00;
    cyc(16);
    uv_clr = 8'hFF;
    cyc(1);
    uv_clr = 8'h00;
    ovf[c2] = 1'b1;
    cyc(4);
    ovf = 8'h00;
    cyc(16);
    chk("ov_glitch", 0, {uv_flag, ov_flag});
    ovf[c2] = 1'b1;
    cyc(16);
    chk("ov_flag", 32'(8'h01 << c2), ov_flag);
    chk("rst_unmapped", 1, rst_oe_n);
    ovf = 8'h01 << ch;
    cyc(12);
    chk("ov_flag", 32'((8'h01 << ch) | (8'h01 << c2)), ov_flag);
    chk("pins", 0, {rst_oe_n, irq_oe_n});
    ov_clr = 8'hFF;
    cyc(1);
    ov_clr = 8'h00;
    cyc(2);
    chk("ov_flag", 32'(8'h01 << ch), ov_flag);
    ov_en = 8'h00;
    cyc(3);
    chk("irq_oe_n", 0, irq_oe_n);
    ext_low = 1'b1;
    ovf = 8'h00;
    wait_for(1, 1, d + 20, n);
    chk("rst_delay", 1, n >= d && n <= d + 6);
    wait_for(2, 1, 120, n);
    chk("settle", 1, n >= 48 && n <= 70);
    ext_low = 1'b0;
    cyc(3);
    ov_clr = 8'hFF;
    mm_clr = 1'b1;
    cyc(1);
    ov_clr = 8'h00;
    mm_clr = 1'b0;
    cyc(3);
    chk("irq_oe_n", 1, irq_oe_n);
    act = 1'b0;
    wait_for(0, 32'(svfo_pkg::ST_SEQ_OFF), 6, n);
    wait_for(0, 32'(svfo_pkg::ST_SELF_TEST), 30, n);
    cyc(2);
    chk("self_test_pins", 32'h1, {rst_oe_n, irq_oe_n});
    wait_for(0, 32'(svfo_pkg::ST_IDLE), 3000, n);
    chk("done_flag", 1, dn_flag);
    summarize();
  end
endmodule : svfo_bench
